// ### include/pscfg_defs.svh
`ifndef PSCFG_DEFS_SVH
`define PSCFG_DEFS_SVH
// How it works
// - The control-path select pin is caught once after reset release and holds for the session.
// - The lane layout pins choose one data output per converter or shared time-multiplexed outputs.
// - Under pin-strap control the analog input precharge buffers are enabled with no host action.
// - Under pin-strap control the reference precharge buffers stay disabled.
// - Under pin-strap control a defined strap-derived setup is loaded after power-up and reset.
// - One filter for all channels: sinc5 when the filter pin is high, wideband when low.
// - Ratio select pins 00/01/10/11 give decimation 32/64/128/1024 for all channels.
// - Modulator rate is the master clock divided by 4 fast, 8 median, 32 low power.
// - Four operating strap pins decode to sixteen power, data clock and conversion settings.

// ---------------------------------------------------------------
// decode constants
// ---------------------------------------------------------------
`define PSCFG_DEC_32 11'h020
`define PSCFG_DEC_64 11'h040
`define PSCFG_DEC_128 11'h080
`define PSCFG_DEC_1024 11'h400
`define PSCFG_MOD_DIV_FAST 6'h04
`define PSCFG_MOD_DIV_MED 6'h08
`define PSCFG_MOD_DIV_LOW 6'h20
`define PSCFG_DCLK_DIV_RST 2'h0
`define PSCFG_DEC_SEL_RST 2'h0
`define PSCFG_OPMODE_RST 4'h0
`endif

// ### include/pscfg_pkg.sv
package pscfg_pkg;
    typedef enum logic [1:0] {
        PSCFG_PWR_LOW = 2'b00,
        PSCFG_PWR_MED = 2'b01,
        PSCFG_PWR_FAST = 2'b10
    } pscfg_pwr_e;

    typedef enum logic [1:0] {
        PSCFG_ST_BOOT = 2'b00,
        PSCFG_ST_LOAD = 2'b01,
        PSCFG_ST_RUN = 2'b10
    } pscfg_state_e;

    typedef struct packed {
        pscfg_pwr_e pwr;
        logic [1:0] dclk_div;
        logic one_shot;
    } pscfg_op_s;
endpackage

// ### include/pscfg_op_if.sv
`timescale 1ns/1ps
interface pscfg_op_if;
    logic [3:0] straps;
    pscfg_pkg::pscfg_op_s op;
    modport decoder (input straps, output op);
    modport user (output straps, input op);
endinterface

// ### logic/pscfg_op_decode.sv
`timescale 1ns/1ps
`include "pscfg_defs.svh"
module pscfg_op_decode
    import pscfg_pkg::*;
(
    pscfg_op_if.decoder dec
);
    // ---------------------------------------------------------------
    // operating strap table, sixteen entries
    // ---------------------------------------------------------------
    always_comb begin
        dec.op.one_shot = 1'b0;
        dec.op.dclk_div = dec.straps[1:0];
        dec.op.pwr = PSCFG_PWR_LOW;
        if (dec.straps[3:2] == 2'b00) begin
            dec.op.pwr = PSCFG_PWR_LOW;
        end else if (dec.straps[3:2] == 2'b01) begin
            dec.op.pwr = PSCFG_PWR_MED;
        end else if (dec.straps[3:2] == 2'b10) begin
            dec.op.pwr = PSCFG_PWR_FAST;
        end else begin
            // top quarter of the table selects one-shot conversion
            dec.op.one_shot = 1'b1;
            case (dec.straps[1:0])
                2'b00: begin
                    dec.op.pwr = PSCFG_PWR_LOW;
                    dec.op.dclk_div = 2'h0;
                end
                2'b01: begin
                    dec.op.pwr = PSCFG_PWR_MED;
                    dec.op.dclk_div = 2'h0;
                end
                2'b10: begin
                    dec.op.pwr = PSCFG_PWR_FAST;
                    dec.op.dclk_div = 2'h1;
                end
                default: begin
                    dec.op.pwr = PSCFG_PWR_FAST;
                    dec.op.dclk_div = 2'h0;
                end
            endcase
        end
    end
endmodule

// ### logic/pscfg_top.sv
`timescale 1ns/1ps
`include "pscfg_defs.svh"
module pscfg_top
    import pscfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic spi_select_pin,
    input wire logic filter_pin,
    input wire logic ratio_select_high,
    input wire logic ratio_select_low,
    input wire logic [3:0] operating_strap_pins,
    input wire logic [1:0] lane_layout_pins,
    input wire logic start_pin,
    input wire logic resync_pin,
    output logic spi_mode,
    output logic cfg_valid,
    output logic sinc5_sel,
    output logic [10:0] decim_ratio,
    output logic [5:0] mod_div,
    output logic [1:0] dclk_div,
    output logic one_shot,
    output logic [1:0] pwr_mode,
    output logic [1:0] lane_layout,
    output logic ain_prechg_en,
    output logic ref_prechg_en
);
    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    typedef struct packed {
        pscfg_state_e st;
        logic fill;
        logic [11:0] s1;
        logic [11:0] s2;
        logic sync_last;
        logic spi;
        logic valid;
        logic sinc5;
        logic [10:0] dec;
        logic [5:0] mdiv;
        logic [1:0] dclk;
        logic oneshot;
        logic [1:0] pwr;
        logic [1:0] lanes;
        logic ain;
        logic refb;
    } pscfg_reg_s;

    pscfg_reg_s cur_q;
    pscfg_reg_s cur_d;
    pscfg_op_if opi ();
    logic edge_now;

    function automatic logic [10:0] pscfg_dec_ratio(input logic [1:0] sel);
        logic [10:0] r;
        r = `PSCFG_DEC_32;
        case (sel)
            2'b00: r = `PSCFG_DEC_32;
            2'b01: r = `PSCFG_DEC_64;
            2'b10: r = `PSCFG_DEC_128;
            default: r = `PSCFG_DEC_1024;
        endcase
        return r;
    endfunction

    function automatic logic [5:0] pscfg_mod_div(input pscfg_pwr_e p);
        logic [5:0] r;
        r = `PSCFG_MOD_DIV_LOW;
        case (p)
            PSCFG_PWR_FAST: r = `PSCFG_MOD_DIV_FAST;
            PSCFG_PWR_MED: r = `PSCFG_MOD_DIV_MED;
            default: r = `PSCFG_MOD_DIV_LOW;
        endcase
        return r;
    endfunction

    // synchronised pins: [11] start, [10] resync, [9] spi sel, [8] filter, [7:6] ratio,
    // [5:2] op, [1:0] lanes
    assign opi.straps = cur_q.s2[5:2];
    // sync edge: the two requests merge only after their second stage, so each raw pin
    // passes its own two flops before the detector sees it
    assign edge_now = (cur_q.s2[11] | cur_q.s2[10]) & ~cur_q.sync_last;

    pscfg_op_decode u_dec (
        .dec(opi)
    );

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        cur_d = cur_q;
        // two flops on every pin before anything reads it
        cur_d.s1 = {start_pin, resync_pin, spi_select_pin, filter_pin, ratio_select_high,
                    ratio_select_low, operating_strap_pins, lane_layout_pins};
        cur_d.s2 = cur_q.s1;
        // detection flop reads only the second stage, the first stays private
        cur_d.sync_last = cur_q.s2[11] | cur_q.s2[10];
        cur_d.lanes = cur_q.s2[1:0];
        cur_d.refb = 1'b0;
        case (cur_q.st)
            PSCFG_ST_BOOT: begin
                // two edges let both stages fill before the select level is sampled
                cur_d.fill = 1'b1;
                if (cur_q.fill) begin
                    cur_d.st = PSCFG_ST_LOAD;
                end
            end
            PSCFG_ST_LOAD: begin
                cur_d.spi = cur_q.s2[9];
                cur_d.st = PSCFG_ST_RUN;
                cur_d.valid = 1'b1;
                cur_d.ain = ~cur_q.s2[9];
                // strap defaults loaded without waiting for a sync
                cur_d.sinc5 = cur_q.s2[8];
                cur_d.dec = pscfg_dec_ratio(cur_q.s2[7:6]);
                cur_d.mdiv = pscfg_mod_div(opi.op.pwr);
                cur_d.dclk = opi.op.dclk_div;
                cur_d.oneshot = opi.op.one_shot;
                cur_d.pwr = opi.op.pwr;
            end
            default: begin
                // select level held for the session; later straps wait for sync
                if (edge_now && !cur_q.spi) begin
                    cur_d.sinc5 = cur_q.s2[8];
                    cur_d.dec = pscfg_dec_ratio(cur_q.s2[7:6]);
                    cur_d.mdiv = pscfg_mod_div(opi.op.pwr);
                    cur_d.dclk = opi.op.dclk_div;
                    cur_d.oneshot = opi.op.one_shot;
                    cur_d.pwr = opi.op.pwr;
                end
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= '{st: PSCFG_ST_BOOT, fill: 1'b0, s1: 12'h000, s2: 12'h000,
                       sync_last: 1'b0,
                       spi: 1'b0, valid: 1'b0, sinc5: 1'b0, dec: `PSCFG_DEC_32,
                       mdiv: `PSCFG_MOD_DIV_LOW, dclk: `PSCFG_DCLK_DIV_RST,
                       oneshot: 1'b0, pwr: 2'b00, lanes: 2'b00, ain: 1'b0, refb: 1'b0};
        end else begin
            cur_q <= cur_d;
        end
    end

    // every output straight from the state register
    assign spi_mode = cur_q.spi;
    assign cfg_valid = cur_q.valid;
    assign sinc5_sel = cur_q.sinc5;
    assign decim_ratio = cur_q.dec;
    assign mod_div = cur_q.mdiv;
    assign dclk_div = cur_q.dclk;
    assign one_shot = cur_q.oneshot;
    assign pwr_mode = cur_q.pwr;
    assign lane_layout = cur_q.lanes;
    assign ain_prechg_en = cur_q.ain;
    assign ref_prechg_en = cur_q.refb;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    property p_spi_hold;
        @(posedge clk) disable iff (!rst_n)
        (cur_q.st == PSCFG_ST_RUN) |=> $stable(spi_mode);
    endproperty
    a_spi_hold: assert property (p_spi_hold) else $error("select changed in session");

    property p_lanes;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (lane_layout == $past(cur_q.s2[1:0]));
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane layout not followed");

    property p_ain;
        @(posedge clk) disable iff (!rst_n)
        (cfg_valid && !spi_mode) |-> ain_prechg_en;
    endproperty
    a_ain: assert property (p_ain) else $error("input precharge off");

    property p_ref;
        @(posedge clk) disable iff (!rst_n)
        !spi_mode |-> !ref_prechg_en;
    endproperty
    a_ref: assert property (p_ref) else $error("reference precharge on");

    property p_boot;
        @(posedge clk) disable iff (!rst_n)
        (cur_q.st == PSCFG_ST_BOOT && !cur_q.fill) |-> ##3 cfg_valid;
    endproperty
    a_boot: assert property (p_boot) else $error("no config after reset");

    property p_commit;
        @(posedge clk) disable iff (!rst_n)
        (cur_q.st == PSCFG_ST_RUN && !spi_mode && edge_now)
            |=> (sinc5_sel == $past(cur_q.s2[8]))
            && (decim_ratio == pscfg_dec_ratio($past(cur_q.s2[7:6])));
    endproperty
    a_commit: assert property (p_commit) else $error("sync commit wrong");

    property p_mod;
        @(posedge clk) disable iff (!rst_n)
        cfg_valid |-> (mod_div == pscfg_mod_div(pscfg_pwr_e'(pwr_mode)));
    endproperty
    a_mod: assert property (p_mod) else $error("modulator divider mismatch");

    property p_oneshot;
        @(posedge clk) disable iff (!rst_n)
        (cfg_valid && one_shot) |-> (dclk_div <= 2'h1);
    endproperty
    a_oneshot: assert property (p_oneshot) else $error("one-shot divider out of table");

    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (cur_q.st == PSCFG_ST_RUN && !edge_now) |=> $stable(decim_ratio) && $stable(sinc5_sel);
    endproperty
    a_hold: assert property (p_hold) else $error("setting changed without sync");

    c_sync: cover property (@(posedge clk) disable iff (!rst_n)
        edge_now && !spi_mode && cur_q.st == PSCFG_ST_RUN);
    c_spi: cover property (@(posedge clk) disable iff (!rst_n) cfg_valid && spi_mode);
    c_1024: cover property (@(posedge clk) disable iff (!rst_n) decim_ratio == `PSCFG_DEC_1024);
endmodule

// ### tb/pscfg_host_model.sv
`timescale 1ns/1ps
module pscfg_host_model (
    input wire logic clk,
    output logic rst_n,
    output logic start_pin,
    output logic resync_pin
);
    // ---------------------------------------------------------------
    // power-up state
    // ---------------------------------------------------------------
    // reset is held from time zero so nothing is relied on before it
    initial begin
        rst_n = 1'h0;
        start_pin = 1'h0;
        resync_pin = 1'h0;
    end

    // ---------------------------------------------------------------
    // host actions, always launched off the falling edge
    // ---------------------------------------------------------------
    // reset level change
    task automatic drive_reset(input logic level);
        @(negedge clk);
        rst_n = level;
    endtask

    // two-cycle pulse so both sync flops see it; pins released low after
    task automatic sync_pulse(input logic use_resync);
        @(negedge clk);
        if (use_resync) begin
            resync_pin = 1'h1;
        end else begin
            start_pin = 1'h1;
        end
        repeat (2) @(negedge clk);
        start_pin = 1'h0;
        resync_pin = 1'h0;
    endtask
endmodule

// ### tb/pin_strap_adc_config_bench.sv
`timescale 1ns/1ps
module pin_strap_adc_config_bench;
    import pscfg_pkg::*;
    logic clk, rst_n, spi_select_pin, filter_pin, ratio_select_high, ratio_select_low;
    logic start_pin, resync_pin, spi_mode, cfg_valid, sinc5_sel, one_shot;
    logic ain_prechg_en, ref_prechg_en;
    logic [3:0] operating_strap_pins;
    logic [1:0] lane_layout_pins, dclk_div, pwr_mode, lane_layout;
    logic [10:0] decim_ratio;
    logic [5:0] mod_div;
    int mismatches, comparisons;
    logic pf;
    logic [1:0] pd;
    logic [3:0] pm;

    pscfg_host_model host (.clk(clk), .rst_n(rst_n), .start_pin(start_pin),
        .resync_pin(resync_pin));

    pscfg_top uut (.clk(clk), .rst_n(rst_n), .spi_select_pin(spi_select_pin),
        .filter_pin(filter_pin), .ratio_select_high(ratio_select_high),
        .ratio_select_low(ratio_select_low), .operating_strap_pins(operating_strap_pins),
        .lane_layout_pins(lane_layout_pins), .start_pin(start_pin),
        .resync_pin(resync_pin), .spi_mode(spi_mode), .cfg_valid(cfg_valid),
        .sinc5_sel(sinc5_sel), .decim_ratio(decim_ratio), .mod_div(mod_div),
        .dclk_div(dclk_div), .one_shot(one_shot), .pwr_mode(pwr_mode),
        .lane_layout(lane_layout), .ain_prechg_en(ain_prechg_en),
        .ref_prechg_en(ref_prechg_en));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // 200 MHz master clock
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end

    // {pwr, dclk_div, one_shot}; only the top four entries break the pattern
    function automatic logic [4:0] exp_op(input logic [3:0] m);
        case (m)
            4'hc: return 5'h01;
            4'hd: return 5'h09;
            4'he: return 5'h13;
            4'hf: return 5'h11;
            default: return {m[3] ? 2'h2 : {1'h0, m[2]}, m[1:0], 1'h0};
        endcase
    endfunction

    task automatic chk(input string name, input logic [10:0] exp, input logic [10:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // filter, ratio, operating and precharge outputs against the strap levels they should reflect
    task automatic check_all(input logic f, input logic [1:0] d, input logic [3:0] m);
        logic [4:0] o;
        logic [10:0] dr[4];
        logic [5:0] md[3];
        dr = '{11'h020, 11'h040, 11'h080, 11'h400};
        md = '{6'h20, 6'h08, 6'h04};
        o = exp_op(m);
        chk("sinc5_sel", 11'(f), 11'(sinc5_sel));
        chk("decim_ratio", dr[d], decim_ratio);
        chk("pwr_mode", 11'(o[4:3]), 11'(pwr_mode));
        chk("dclk_div", 11'(o[2:1]), 11'(dclk_div));
        chk("one_shot", 11'(o[0]), 11'(one_shot));
        chk("mod_div", 11'(md[o[4:3]]), 11'(mod_div));
        chk("ain_prechg_en", 11'h001, 11'(ain_prechg_en));
        chk("ref_prechg_en", 11'h000, 11'(ref_prechg_en));
    endtask

    // reset with the given select level, then a bounded wait for the load
    task automatic do_reset(input logic sel);
        int n;
        host.drive_reset(1'h0);
        spi_select_pin = sel;
        repeat (2) @(negedge clk);
        chk("cfg_valid", 11'h000, 11'(cfg_valid));
        chk("decim_ratio", 11'h020, decim_ratio);
        chk("mod_div", 11'h020, 11'(mod_div));
        host.drive_reset(1'h1);
        n = 0;
        while (cfg_valid !== 1'h1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        // a load that never comes is counted here and the run goes on to the report
        chk("cfg_valid", 11'h001, 11'(cfg_valid));
        repeat (2) @(negedge clk);
        chk("spi_mode", 11'(sel), 11'(spi_mode));
    endtask

    task automatic set_straps(input logic f, input logic [1:0] d, input logic [3:0] m);
        filter_pin = f;
        {ratio_select_high, ratio_select_low} = d;
        operating_strap_pins = m;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        mismatches = 0;
        comparisons = 0;
        spi_select_pin = 1'h0;
        lane_layout_pins = 2'h0;
        set_straps(1'h1, 2'h3, 4'hf);
        do_reset(1'h0);
        check_all(1'h1, 2'h3, 4'hf);
        {pf, pd, pm} = {1'h1, 2'h3, 4'hf};
        // every operating code; each step changes all straps so a leak shows
        for (int i = 0; i < 16; i++) begin
            @(negedge clk);
            set_straps(i[0], i[1:0], i[3:0]);
            repeat (6) @(negedge clk);
            check_all(pf, pd, pm);
            host.sync_pulse(i[0]);
            repeat (6) @(negedge clk);
            check_all(i[0], i[1:0], i[3:0]);
            {pf, pd, pm} = {i[0], i[1:0], i[3:0]};
        end
        // lane arrangement follows its pins without any sync
        for (int j = 0; j < 4; j++) begin
            lane_layout_pins = j[1:0];
            repeat (5) @(negedge clk);
            chk("lane_layout", 11'(j[1:0]), 11'(lane_layout));
        end
        // serial control: select moves mid-session, syncs must be ignored
        do_reset(1'h1);
        spi_select_pin = 1'h0;
        set_straps(1'h0, 2'h1, 4'h5);
        host.sync_pulse(1'h0);
        repeat (6) @(negedge clk);
        chk("spi_mode", 11'h001, 11'(spi_mode));
        chk("ain_prechg_en", 11'h000, 11'(ain_prechg_en));
        chk("decim_ratio", 11'h400, decim_ratio);
        chk("sinc5_sel", 11'h001, 11'(sinc5_sel));
        // back to pin control: straps present at reset are loaded directly
        do_reset(1'h0);
        check_all(1'h0, 2'h1, 4'h5);
        tally_and_finish();
    end
endmodule
